// ### tb/crag_asserts.sv
// concurrent checks on the ports of the operand address generator
`timescale 1ns/100ps

module crag_asserts
  import crag_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request
  input wire logic req_valid,
  input wire crag_pkg::crag_mode_type req_mode,
  input wire logic req_amode,
  input wire logic req_write,
  input wire crag_pkg::crag_reg16_type req_reg16_sel,
  input wire logic [2:0] req_aux_sel,
  input wire logic [31:0] req_wdata,
  input wire logic [15:0] req_imm,
  input wire logic req_rpt_next,
  // bus and register view
  input wire logic bus_valid,
  input wire crag_pkg::crag_space_type bus_space,
  input wire logic [31:0] data_addr,
  input wire logic [21:0] prog_addr,
  input wire logic io_strobe,
  input wire logic flag_update,
  input wire logic [2:0] pointer_select,
  input wire logic [31:0] main_sum_reg,
  input wire logic [31:0] circ_base_ptr,
  input wire logic [31:0] circ_index_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_io_strobe_pair: assert property (
    io_strobe |-> bus_valid && bus_space == CRAG_SPACE_IO) else $error("io strobe outside io cycle");
  a_data_imm_addr: assert property (
    req_valid && req_mode == CRAG_MODE_IMM_DATA && !req_rpt_next |=> bus_valid && data_addr == {16'h0000, $past(req_imm)})
    else $error("data immediate address wrong");
  a_io_imm_addr: assert property (
    req_valid && req_mode == CRAG_MODE_IMM_IO && !req_rpt_next |=> io_strobe && data_addr == {16'h0000, $past(req_imm)})
    else $error("io immediate address wrong");
  a_low_prog_page: assert property (
    req_valid && req_mode == CRAG_MODE_IMM_PLOW |=> prog_addr[21:16] == 6'h00 && bus_space == CRAG_SPACE_PROG)
    else $error("low program page wrong");
  a_high_prog_page: assert property (
    req_valid && req_mode == CRAG_MODE_IMM_PHIGH |=> prog_addr[21:16] == 6'h3f && bus_space == CRAG_SPACE_PROG)
    else $error("high program page wrong");
  a_repeat_step: assert property (
    req_valid && req_mode == CRAG_MODE_IMM_PHIGH ##1 req_valid && req_mode == CRAG_MODE_IMM_PHIGH && req_rpt_next
    |=> prog_addr[15:0] == $past(prog_addr[15:0]) + 16'h0001) else $error("repeat did not step by one");
  a_reg_no_bus: assert property (
    req_valid && req_mode inside {CRAG_MODE_REG32, CRAG_MODE_REG16} |=> !bus_valid) else $error("register op on bus");
  a_circ_ptr_sel: assert property (
    req_valid && req_mode == CRAG_MODE_CIRC |=> bus_valid && pointer_select == 3'h6) else $error("pointer select not 6");
  a_wide_circ_addr: assert property (
    req_valid && req_mode == CRAG_MODE_CIRC && req_amode
    |=> data_addr == $past(circ_base_ptr) + {16'h0000, $past(circ_index_reg[15:0])}
    && circ_index_reg[31:16] == $past(circ_index_reg[31:16])) else $error("wide circular address wrong");
  a_narrow_circ_addr: assert property (
    req_valid && req_mode == CRAG_MODE_CIRC && !req_amode
    |=> data_addr == $past(circ_base_ptr) && circ_base_ptr[31:16] == $past(circ_base_ptr[31:16]))
    else $error("narrow circular address wrong");
  a_sum_low_keep: assert property (
    req_valid && req_mode == CRAG_MODE_REG16 && req_write && req_reg16_sel == CRAG_R16_SUM_LO
    |=> flag_update && main_sum_reg == {$past(main_sum_reg[31:16]), $past(req_wdata[15:0])})
    else $error("sum low write touched upper word");
  a_aux_low_keep: assert property (
    req_valid && req_mode == CRAG_MODE_REG16 && req_write && req_reg16_sel == CRAG_R16_AUX_LO && req_aux_sel == 3'h1
    |=> circ_index_reg == {$past(circ_index_reg[31:16]), $past(req_wdata[15:0])}) else $error("aux low write wrong");
endmodule

bind circ_reg_imm_address_gen crag_asserts crag_asserts_i (.mclk, .reset, .req_valid, .req_mode, .req_amode,
  .req_write, .req_reg16_sel, .req_aux_sel, .req_wdata, .req_imm, .req_rpt_next, .bus_valid, .bus_space,
  .data_addr, .prog_addr, .io_strobe, .flag_update, .pointer_select, .main_sum_reg, .circ_base_ptr,
  .circ_index_reg);

// ### tb/crag_bus_model.sv
// memory and i/o bus side: counts the bus cycles it is offered
`timescale 1ns/100ps

module crag_bus_model
  import crag_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bus request
  input wire logic bus_valid,
  input wire logic io_strobe,
  input wire crag_pkg::crag_space_type bus_space,
  // activity counters
  output int n_bus,
  output int n_io
);
  always @(posedge mclk) begin
    if (reset) begin
      n_bus <= 0;
      n_io <= 0;
    end else begin
      if (bus_valid) n_bus <= n_bus + 1;
      if (io_strobe && bus_space == CRAG_SPACE_IO) n_io <= n_io + 1;
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench of the operand address generator
`timescale 1ns/100ps

module testbench;
  import crag_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0, req_amode = 1'b0, req_is32 = 1'b0, req_write = 1'b0, req_rpt_next = 1'b0;
  crag_mode_type req_mode = CRAG_MODE_NONE;
  crag_reg32_type req_reg32_sel = CRAG_R32_SUM;
  crag_reg16_type req_reg16_sel = CRAG_R16_SUM_LO;
  logic [2:0] req_aux_sel = 3'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [15:0] req_imm = 16'h0;
  logic bus_valid, bus_write, bus_is32, io_strobe, rd_valid, flag_update;
  crag_space_type bus_space;
  logic [31:0] data_addr, bus_wdata, rd_data, main_sum_reg, product_reg, multiplicand_reg, circ_base_ptr, circ_index_reg;
  logic [21:0] prog_addr;
  logic [2:0] pointer_select;
  logic [15:0] stack_top_reg;
  int miscompares = 0, n_compared = 0, n_exp_bus = 0, n_bus, n_io;
  logic [31:0] m_sum = 32'h0, m_prod = 32'h0, m_mult = 32'h0;
  logic [31:0] m_aux [8] = '{default: 32'h0};
  logic [15:0] m_sp = 16'h0;

  always #12.5 mclk = ~mclk;

  circ_reg_imm_address_gen circ_reg_imm_address_gen_i (.mclk, .reset, .req_valid, .req_mode, .req_amode, .req_is32,
    .req_write, .req_reg32_sel, .req_reg16_sel, .req_aux_sel, .req_wdata, .req_imm, .req_rpt_next, .bus_valid,
    .bus_space, .bus_write, .bus_is32, .data_addr, .prog_addr, .bus_wdata, .io_strobe, .rd_valid, .rd_data,
    .flag_update, .pointer_select, .main_sum_reg, .product_reg, .multiplicand_reg, .stack_top_reg, .circ_base_ptr,
    .circ_index_reg);
  crag_bus_model crag_bus_model_i (.mclk, .reset, .bus_valid, .io_strobe, .bus_space, .n_bus, .n_io);

  task automatic final_report;
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(string nm, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one request taken at the next edge; returns just after it
  task automatic go(crag_mode_type m, logic am, logic w32, logic wr, logic [2:0] s, logic [2:0] ax,
                    logic [31:0] wd, logic [15:0] im, logic rp);
    req_valid = 1'b1;
    req_mode = m;
    req_amode = am;
    req_is32 = w32;
    req_write = wr;
    req_reg32_sel = crag_reg32_type'(s[1:0]);
    req_reg16_sel = crag_reg16_type'(s);
    req_aux_sel = ax;
    req_wdata = wd;
    req_imm = im;
    req_rpt_next = rp;
    @(posedge mclk);
    #2;
  endtask

  task automatic idle;
    req_valid = 1'b0;
    @(posedge mclk);
    #2;
  endtask

  function automatic void wr_model(logic w32, logic [2:0] s, logic [2:0] ax, logic [31:0] d);
    if (w32) case (s[1:0])
      2'h0: m_sum = d;
      2'h1: m_prod = d;
      2'h2: m_mult = d;
      default: m_aux[ax] = d;
    endcase
    else case (s)
      3'h0: m_sum[15:0] = d[15:0];
      3'h1: m_sum[31:16] = d[15:0];
      3'h2: m_prod[15:0] = d[15:0];
      3'h3: m_prod[31:16] = d[15:0];
      3'h4: m_mult[31:16] = d[15:0];
      3'h5: m_sp = d[15:0];
      3'h6: m_aux[ax][15:0] = d[15:0];
      default: ;
    endcase
  endfunction

  function automatic logic [31:0] rd_model(logic w32, logic [2:0] s, logic [2:0] ax);
    logic [31:0] v;
    v = 32'h0;
    if (w32) v = s[1:0] == 2'h0 ? m_sum : s[1:0] == 2'h1 ? m_prod : s[1:0] == 2'h2 ? m_mult : m_aux[ax];
    else case (s)
      3'h0: v[15:0] = m_sum[15:0];
      3'h1: v[15:0] = m_sum[31:16];
      3'h2: v[15:0] = m_prod[15:0];
      3'h3: v[15:0] = m_prod[31:16];
      3'h4: v[15:0] = m_mult[31:16];
      3'h5: v[15:0] = m_sp;
      3'h6: v[15:0] = m_aux[ax][15:0];
      default: ;
    endcase
    return v;
  endfunction

  task automatic reg_op(logic w32, logic wr, logic [2:0] s, logic [2:0] ax, logic [31:0] d);
    go(w32 ? CRAG_MODE_REG32 : CRAG_MODE_REG16, 1'b0, w32, wr, s, ax, d, 16'h0, 1'b0);
    if (wr) wr_model(w32, s, ax, d);
    chk_flag("bus_valid", 1'b0, bus_valid);
    chk_flag("rd_valid", !wr, rd_valid);
    if (!wr) chk_val("rd_data", rd_model(w32, s, ax), rd_data);
    chk_flag("flag_update", wr && (w32 ? s[1:0] == 2'h0 : s < 3'h2), flag_update);
    chk_val("main_sum_reg", m_sum, main_sum_reg);
    chk_val("product_reg", m_prod, product_reg);
    chk_val("multiplicand_reg", m_mult, multiplicand_reg);
    chk_val("stack_top_reg", {16'h0, m_sp}, {16'h0, stack_top_reg});
    chk_val("circ_index_reg", m_aux[1], circ_index_reg);
    chk_val("circ_base_ptr", m_aux[6], circ_base_ptr);
  endtask

  task automatic run_circ(logic am, logic w32, logic [31:0] b, logic [31:0] i, int n);
    logic [31:0] ea;
    reg_op(1'b1, 1'b1, 3'h3, 3'h6, b);
    reg_op(1'b1, 1'b1, 3'h3, 3'h1, i);
    repeat (n) begin
      ea = am ? m_aux[6] + {16'h0, m_aux[1][15:0]} : m_aux[6];
      if (!am && m_aux[6][7:0] == m_aux[1][7:0]) m_aux[6][7:0] = 8'h00;
      else if (!am) m_aux[6][15:0] += w32 ? 16'h2 : 16'h1;
      else if (m_aux[1][15:0] == m_aux[1][31:16]) m_aux[1][15:0] = 16'h0;
      else m_aux[1][15:0] += w32 ? 16'h2 : 16'h1;
      go(CRAG_MODE_CIRC, am, w32, 1'b0, 3'h0, 3'h0, 32'h0, 16'h0, 1'b0);
      n_exp_bus++;
      chk_val("data_addr", ea, data_addr);
      chk_flag("bus_is32", w32, bus_is32);
      chk_flag("bus_valid", 1'b1, bus_valid);
      chk_val("pointer_select", 32'h6, {29'h0, pointer_select});
      chk_val("circ_base_ptr", m_aux[6], circ_base_ptr);
      chk_val("circ_index_reg", m_aux[1], circ_index_reg);
    end
    idle;
  endtask

  task automatic run_imm(crag_mode_type m, logic [15:0] im);
    logic [15:0] a;
    logic [31:0] d;
    crag_space_type sp;
    sp = m == CRAG_MODE_IMM_IO ? CRAG_SPACE_IO : m == CRAG_MODE_IMM_DATA ? CRAG_SPACE_DATA : CRAG_SPACE_PROG;
    for (int k = 0; k < 3; k++) begin
      a = im + k[15:0];
      d = $urandom;
      go(m, 1'b0, 1'b0, k[0], 3'h0, 3'h0, d, k == 0 ? im : ~im, k != 0);
      n_exp_bus++;
      chk_flag("bus_valid", 1'b1, bus_valid);
      chk_flag("bus_write", k[0], bus_write);
      chk_val("bus_wdata", d, bus_wdata);
      chk_flag("io_strobe", m == CRAG_MODE_IMM_IO, io_strobe);
      chk_val("bus_space", {30'h0, sp}, {30'h0, bus_space});
      if (m == CRAG_MODE_IMM_PLOW) chk_val("prog_addr", {10'h0, 6'h00, a}, {10'h0, prog_addr});
      else if (m == CRAG_MODE_IMM_PHIGH) chk_val("prog_addr", {10'h0, 6'h3f, a}, {10'h0, prog_addr});
      else chk_val("data_addr", {16'h0000, a}, data_addr);
    end
    idle;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    final_report;
  end

  initial begin
    logic [31:0] b, i;
    void'($urandom(32'h63a5));
    repeat (10) @(posedge mclk);
    #2;
    reset = 1'b0;
    chk_val("pointer_select", 32'h0, {29'h0, pointer_select});
    for (int k = 0; k < 32; k++) reg_op(1'b1, 1'b1, {1'b0, k[4:3]}, k[2:0], $urandom);
    reg_op(1'b0, 1'b1, 3'h0, 3'h0, $urandom);
    reg_op(1'b0, 1'b1, 3'h6, 3'h1, $urandom);
    for (int k = 0; k < 80; k++) reg_op(1'b0, 1'($urandom), 3'($urandom), 3'($urandom), $urandom);
    for (int k = 0; k < 32; k++) reg_op(1'b1, 1'b0, {1'b0, k[4:3]}, k[2:0], 32'h0);
    for (int w = 0; w < 2; w++) begin
      i = {24'($urandom), 8'($urandom_range(255))} & {31'h7fffffff, w == 0};
      b = {24'($urandom), 8'($urandom_range(i[7:0]))} & {31'h7fffffff, w == 0};
      run_circ(1'b0, w[0], {b[31:8], 8'h00} | b[7:0], i, i[7:0] + 4);
      i = {16'($urandom_range(40)) & {15'h7fff, w == 0}, 16'h0};
      i[15:0] = 16'($urandom_range(i[31:16])) & {15'h7fff, w == 0};
      run_circ(1'b1, w[0], $urandom & {31'h7fffffff, w == 0}, i, 46);
    end
    run_circ(1'b0, 1'b0, 32'h0001_2300, 32'h0000_00ff, 260);
    run_circ(1'b0, 1'b0, 32'h0004_5600, 32'h0000_0000, 3);
    run_circ(1'b1, 1'b1, 32'h0001_fff0, 32'h0020_0010, 20);
    for (int k = 0; k < 4; k++) begin
      run_imm(crag_mode_type'(k + 4), 16'($urandom));
      run_imm(crag_mode_type'(k + 4), 16'hffff);
    end
    chk_val("io cycles", 32'd6, n_io);
    chk_val("bus cycles", n_exp_bus, n_bus);
    final_report;
  end
endmodule

// ### verilog/circ_reg_imm_address_gen.sv
// operand address generator: circular, register and immediate modes
`timescale 1ns/100ps

module circ_reg_imm_address_gen #(
  parameter int NUM_AUX = crag_pkg::AUX_NUM
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // operand request from the decoder
  input wire logic req_valid,
  input wire crag_pkg::crag_mode_type req_mode,
  input wire logic req_amode,
  input wire logic req_is32,
  input wire logic req_write,
  input wire crag_pkg::crag_reg32_type req_reg32_sel,
  input wire crag_pkg::crag_reg16_type req_reg16_sel,
  input wire logic [2:0] req_aux_sel,
  input wire logic [31:0] req_wdata,
  input wire logic [15:0] req_imm,
  input wire logic req_rpt_next,
  // memory and i/o bus request
  output logic bus_valid,
  output crag_pkg::crag_space_type bus_space,
  output logic bus_write,
  output logic bus_is32,
  output logic [31:0] data_addr,
  output logic [21:0] prog_addr,
  output logic [31:0] bus_wdata,
  output logic io_strobe,
  // register operand result
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic flag_update,
  // register file view
  output logic [2:0] pointer_select,
  output logic [31:0] main_sum_reg,
  output logic [31:0] product_reg,
  output logic [31:0] multiplicand_reg,
  output logic [15:0] stack_top_reg,
  output logic [31:0] circ_base_ptr,
  output logic [31:0] circ_index_reg
);
  import crag_pkg::*;

  if (NUM_AUX != AUX_NUM) begin : g_aux_check
    $error("NUM_AUX must be 8: the aux select is three bits wide");
  end

  // register file and registered bus outputs share one state word
  typedef struct packed {
    logic [31:0] sum;
    logic [31:0] prod;
    logic [31:0] mult;
    logic [7:0][31:0] aux;
    logic [15:0] sp;
    logic [2:0] psel;
    logic bus_valid;
    crag_space_type bus_space;
    logic bus_write;
    logic bus_is32;
    logic [31:0] data_addr;
    logic [21:0] prog_addr;
    logic [31:0] bus_wdata;
    logic io_strobe;
    logic rd_valid;
    logic [31:0] rd_data;
    logic flag_update;
  } crag_state_type;

  crag_state_type cur_ff;
  crag_state_type nxt_state;

  crag_circ_if circ ();
  crag_imm_if imm_bus ();

  crag_circ_unit u_circ (
    .circ(circ.unit)
  );

  crag_imm_unit u_imm (
    .mclk(mclk),
    .reset(reset),
    .imm_bus(imm_bus.unit)
  );

  assign circ.base = cur_ff.aux[CIRC_BASE_NUM];
  assign circ.index = cur_ff.aux[CIRC_INDEX_NUM];
  assign circ.is32 = req_is32;
  assign circ.wide_mode = req_amode;

  // the shadow follows every immediate issue, so a repeat continues from the last address
  assign imm_bus.take = req_valid && (req_mode inside {CRAG_MODE_IMM_DATA, CRAG_MODE_IMM_IO,
                                                       CRAG_MODE_IMM_PLOW, CRAG_MODE_IMM_PHIGH});
  assign imm_bus.rpt_next = req_rpt_next;
  assign imm_bus.imm = req_imm;

  always_comb begin
    nxt_state = cur_ff;
    nxt_state.bus_valid = 1'b0;
    nxt_state.io_strobe = 1'b0;
    nxt_state.rd_valid = 1'b0;
    nxt_state.flag_update = 1'b0;
    if (req_valid) begin
      case (req_mode)
        CRAG_MODE_CIRC: begin
          nxt_state.bus_valid = 1'b1;
          nxt_state.bus_space = CRAG_SPACE_DATA;
          nxt_state.bus_write = req_write;
          nxt_state.bus_is32 = req_is32;
          nxt_state.bus_wdata = req_wdata;
          nxt_state.data_addr = circ.addr;
          // base and index writes come from the unit; the unused one is unchanged
          nxt_state.aux[CIRC_BASE_NUM] = circ.nxt_base;
          nxt_state.aux[CIRC_INDEX_NUM] = circ.nxt_index;
          nxt_state.psel = CIRC_BASE_NUM;
        end
        CRAG_MODE_REG32: begin
          // register operands never reach the bus
          nxt_state.rd_valid = !req_write;
          case (req_reg32_sel)
            CRAG_R32_SUM: begin
              nxt_state.rd_data = cur_ff.sum;
              if (req_write) begin
                nxt_state.sum = req_wdata;
                nxt_state.flag_update = 1'b1;
              end
            end
            CRAG_R32_PROD: begin
              nxt_state.rd_data = cur_ff.prod;
              if (req_write) begin
                nxt_state.prod = req_wdata;
              end
            end
            CRAG_R32_MULT: begin
              nxt_state.rd_data = cur_ff.mult;
              if (req_write) begin
                nxt_state.mult = req_wdata;
              end
            end
            default: begin
              nxt_state.rd_data = cur_ff.aux[req_aux_sel];
              if (req_write) begin
                nxt_state.aux[req_aux_sel] = req_wdata;
              end
            end
          endcase
        end
        CRAG_MODE_REG16: begin
          nxt_state.rd_valid = !req_write;
          case (req_reg16_sel)
            CRAG_R16_SUM_LO: begin
              nxt_state.rd_data = {16'h0000, cur_ff.sum[15:0]};
              if (req_write) begin
                nxt_state.sum = crag_set_low(cur_ff.sum, req_wdata[15:0]);
                nxt_state.flag_update = 1'b1;
              end
            end
            CRAG_R16_SUM_HI: begin
              nxt_state.rd_data = {16'h0000, cur_ff.sum[31:16]};
              if (req_write) begin
                nxt_state.sum = crag_set_high(cur_ff.sum, req_wdata[15:0]);
                nxt_state.flag_update = 1'b1;
              end
            end
            CRAG_R16_PROD_LO: begin
              nxt_state.rd_data = {16'h0000, cur_ff.prod[15:0]};
              if (req_write) begin
                nxt_state.prod = crag_set_low(cur_ff.prod, req_wdata[15:0]);
              end
            end
            CRAG_R16_PROD_HI: begin
              nxt_state.rd_data = {16'h0000, cur_ff.prod[31:16]};
              if (req_write) begin
                nxt_state.prod = crag_set_high(cur_ff.prod, req_wdata[15:0]);
              end
            end
            CRAG_R16_MULT_HI: begin
              nxt_state.rd_data = {16'h0000, cur_ff.mult[31:16]};
              if (req_write) begin
                nxt_state.mult = crag_set_high(cur_ff.mult, req_wdata[15:0]);
              end
            end
            CRAG_R16_STACK: begin
              nxt_state.rd_data = {16'h0000, cur_ff.sp};
              if (req_write) begin
                nxt_state.sp = req_wdata[15:0];
              end
            end
            CRAG_R16_AUX_LO: begin
              nxt_state.rd_data = {16'h0000, cur_ff.aux[req_aux_sel][15:0]};
              if (req_write) begin
                nxt_state.aux[req_aux_sel] = crag_set_low(cur_ff.aux[req_aux_sel], req_wdata[15:0]);
              end
            end
            default: begin
              // an undefined select reads zero and writes nothing
              nxt_state.rd_data = REG32_RESET;
            end
          endcase
        end
        CRAG_MODE_IMM_DATA, CRAG_MODE_IMM_IO: begin
          nxt_state.bus_valid = 1'b1;
          nxt_state.bus_space = CRAG_SPACE_DATA;
          nxt_state.bus_write = req_write;
          nxt_state.bus_is32 = req_is32;
          nxt_state.bus_wdata = req_wdata;
          nxt_state.data_addr = {IMM_UPPER, imm_bus.addr16};
          // i/o shares the data address lines; only the space and the strobe differ
          if (req_mode == CRAG_MODE_IMM_IO) begin
            nxt_state.bus_space = CRAG_SPACE_IO;
            nxt_state.io_strobe = 1'b1;
          end
        end
        CRAG_MODE_IMM_PLOW, CRAG_MODE_IMM_PHIGH: begin
          nxt_state.bus_valid = 1'b1;
          nxt_state.bus_space = CRAG_SPACE_PROG;
          nxt_state.bus_write = req_write;
          nxt_state.bus_is32 = req_is32;
          nxt_state.bus_wdata = req_wdata;
          if (req_mode == CRAG_MODE_IMM_PHIGH) begin
            nxt_state.prog_addr = {PROG_HIGH_PAGE, imm_bus.addr16};
          end else begin
            nxt_state.prog_addr = {PROG_LOW_PAGE, imm_bus.addr16};
          end
        end
        default: begin
          nxt_state.bus_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_ff <= '{
        sum: REG32_RESET,
        prod: REG32_RESET,
        mult: REG32_RESET,
        aux: '0,
        sp: REG16_RESET,
        psel: PSEL_RESET,
        bus_valid: 1'b0,
        bus_space: CRAG_SPACE_DATA,
        bus_write: 1'b0,
        bus_is32: 1'b0,
        data_addr: REG32_RESET,
        prog_addr: 22'h000000,
        bus_wdata: REG32_RESET,
        io_strobe: 1'b0,
        rd_valid: 1'b0,
        rd_data: REG32_RESET,
        flag_update: 1'b0
      };
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign bus_valid = cur_ff.bus_valid;
  assign bus_space = cur_ff.bus_space;
  assign bus_write = cur_ff.bus_write;
  assign bus_is32 = cur_ff.bus_is32;
  assign data_addr = cur_ff.data_addr;
  assign prog_addr = cur_ff.prog_addr;
  assign bus_wdata = cur_ff.bus_wdata;
  assign io_strobe = cur_ff.io_strobe;
  assign rd_valid = cur_ff.rd_valid;
  assign rd_data = cur_ff.rd_data;
  assign flag_update = cur_ff.flag_update;
  assign pointer_select = cur_ff.psel;
  assign main_sum_reg = cur_ff.sum;
  assign product_reg = cur_ff.prod;
  assign multiplicand_reg = cur_ff.mult;
  assign stack_top_reg = cur_ff.sp;
  assign circ_base_ptr = cur_ff.aux[CIRC_BASE_NUM];
  assign circ_index_reg = cur_ff.aux[CIRC_INDEX_NUM];

endmodule

// ### verilog/crag_circ_unit.sv
// circular indirect address and pointer update arithmetic
`timescale 1ns/100ps

module crag_circ_unit (
  crag_circ_if.unit circ
);
  import crag_pkg::*;

  always_comb begin
    circ.addr = circ.base;
    circ.nxt_base = circ.base;
    circ.nxt_index = circ.index;
    if (!circ.wide_mode) begin
      // buffer length is index low byte plus one
      if (circ.base[7:0] == circ.index[7:0]) begin
        circ.nxt_base = {circ.base[31:8], CIRC8_WRAP};
      end else begin
        circ.nxt_base = crag_set_low(circ.base, circ.base[15:0] + crag_step(circ.is32));
      end
    end else begin
      circ.addr = circ.base + {16'h0000, circ.index[15:0]};
      // buffer length is index high half plus one, no alignment
      if (circ.index[15:0] == circ.index[31:16]) begin
        circ.nxt_index = crag_set_low(circ.index, CIRC16_WRAP);
      end else begin
        circ.nxt_index = crag_set_low(circ.index, circ.index[15:0] + crag_step(circ.is32));
      end
    end
  end

endmodule

// ### verilog/crag_if.sv
// interfaces between the address generator core and its two units
`timescale 1ns/100ps

interface crag_circ_if;
  logic [31:0] base;
  logic [31:0] index;
  logic is32;
  logic wide_mode;
  logic [31:0] addr;
  logic [31:0] nxt_base;
  logic [31:0] nxt_index;
  modport unit (input base, input index, input is32, input wide_mode,
                output addr, output nxt_base, output nxt_index);
  modport core (output base, output index, output is32, output wide_mode,
                input addr, input nxt_base, input nxt_index);
endinterface

interface crag_imm_if;
  logic take;
  logic rpt_next;
  logic [15:0] imm;
  logic [15:0] addr16;
  modport unit (input take, input rpt_next, input imm, output addr16);
  modport core (output take, output rpt_next, output imm, input addr16);
endinterface

// ### verilog/crag_imm_unit.sv
// immediate address source with post-increment shadow for repeats
`timescale 1ns/100ps

module crag_imm_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // core side
  crag_imm_if.unit imm_bus
);
  import crag_pkg::*;

  typedef struct packed {
    logic [15:0] shadow;
  } crag_imm_state_type;

  crag_imm_state_type cur_ff;
  crag_imm_state_type nxt_state;

  // a further iteration uses the previous address plus one
  assign imm_bus.addr16 = imm_bus.rpt_next ? cur_ff.shadow + STEP_REPEAT : imm_bus.imm;

  always_comb begin
    nxt_state = cur_ff;
    if (imm_bus.take) begin
      nxt_state.shadow = imm_bus.addr16;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_ff <= '{shadow: REG16_RESET};
    end else begin
      cur_ff <= nxt_state;
    end
  end

endmodule

// ### verilog/crag_pkg.sv
// package with constants, types and helpers of the operand address generator
package crag_pkg;

  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int PROG_W = 22;
  localparam int AUX_NUM = 8;

  // auxiliary register numbers used by the circular modes
  localparam logic [2:0] CIRC_BASE_NUM = 3'h6;
  localparam logic [2:0] CIRC_INDEX_NUM = 3'h1;

  // program page fields
  localparam logic [5:0] PROG_LOW_PAGE = 6'h00;
  localparam logic [5:0] PROG_HIGH_PAGE = 6'h3f;

  // data address upper half for immediate data and i/o
  localparam logic [15:0] IMM_UPPER = 16'h0000;

  // circular wrap values
  localparam logic [7:0] CIRC8_WRAP = 8'h00;
  localparam logic [15:0] CIRC16_WRAP = 16'h0000;

  // post-increment steps
  localparam logic [15:0] STEP_16BIT = 16'h0001;
  localparam logic [15:0] STEP_32BIT = 16'h0002;
  localparam logic [15:0] STEP_REPEAT = 16'h0001;

  // reset values
  localparam logic [31:0] REG32_RESET = 32'h0000_0000;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [2:0] PSEL_RESET = 3'h0;

  typedef enum logic [3:0] {
    CRAG_MODE_NONE, CRAG_MODE_CIRC, CRAG_MODE_REG32, CRAG_MODE_REG16,
    CRAG_MODE_IMM_DATA, CRAG_MODE_IMM_IO, CRAG_MODE_IMM_PLOW, CRAG_MODE_IMM_PHIGH
  } crag_mode_type;

  typedef enum logic [1:0] {CRAG_R32_SUM, CRAG_R32_PROD, CRAG_R32_MULT, CRAG_R32_AUX} crag_reg32_type;

  typedef enum logic [2:0] {
    CRAG_R16_SUM_LO, CRAG_R16_SUM_HI, CRAG_R16_PROD_LO, CRAG_R16_PROD_HI,
    CRAG_R16_MULT_HI, CRAG_R16_STACK, CRAG_R16_AUX_LO
  } crag_reg16_type;

  typedef enum logic [1:0] {CRAG_SPACE_DATA, CRAG_SPACE_IO, CRAG_SPACE_PROG} crag_space_type;

  // post-increment step for the access width
  function automatic logic [15:0] crag_step(input logic is32);
    crag_step = is32 ? STEP_32BIT : STEP_16BIT;
  endfunction

  // replace only the low half of a word
  function automatic logic [31:0] crag_set_low(input logic [31:0] word, input logic [15:0] half);
    crag_set_low = {word[31:16], half};
  endfunction

  // replace only the high half of a word
  function automatic logic [31:0] crag_set_high(input logic [31:0] word, input logic [15:0] half);
    crag_set_high = {half, word[15:0]};
  endfunction

endpackage
